/* design/bcs_params.svh */
/*
  Constants of the configuration source selector: clock rates, times,
  register offsets, field positions and reset values.
  Assumes it is included by its bare name from the package and the design.
*/
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH

// Clock rates in MHz
`define BCS_SYS_CLK_MHZ 100
`define BCS_MGT_CLK_MHZ 75
`define BCS_LOADER_CLK_MHZ 32

// Times in their own units
`define BCS_HOLD_MS 2000
`define BCS_BLINK_MS 250
`define BCS_PROG_NS 500

// Counter widths
`define BCS_HOLD_W 28
`define BCS_BLINK_W 25
`define BCS_PROG_W 8

// Register bus
`define BCS_ADDR_W 4
`define BCS_DATA_W 32
`define BCS_REG_CTRL 4'h0
`define BCS_REG_STATUS 4'h4
`define BCS_REG_MASK 4'h8
`define BCS_REG_STATE 4'hc

// Control fields
`define BCS_CTRL_RELOAD 0

// Event bits in status and mask
`define BCS_EV_W 4
`define BCS_EV_FAULT 0
`define BCS_EV_DONE 1
`define BCS_EV_CARD 2
`define BCS_EV_PRESS 3
`define BCS_EV_RST 4'h0
`define BCS_MASK_RST 4'h0

// State register fields
`define BCS_ST_STATE_LO 0
`define BCS_ST_FALLBACK 4
`define BCS_ST_CHAIN 5
`define BCS_ST_CARD_LO 6
`define BCS_ST_PORT_LO 9
`define BCS_ST_DONE 11

`endif

/* design/bcs_pkg.sv */
/*
  Types of the configuration source selector: states, ports, pin groups.
  Assumes bcs_params.svh is on the include path.
*/
package bcs_pkg;
  `include "bcs_params.svh"

  typedef enum logic [3:0] {
    ST_FAULT, ST_SAMPLE, ST_START, ST_FLASH, ST_CHECK, ST_CARD, ST_EXT, ST_DONE
  } bcs_state_t;

  typedef enum logic [1:0] {PORT_CARD, PORT_USB, PORT_PAR} bcs_port_t;

  typedef struct packed {
    logic supplyFault;
    logic flashSrc;
    logic chainSrc;
    logic fallback;
    logic done;
    logic activity;
    logic loaderFault;
  } bcs_leds_t;

  typedef struct packed {
    logic [2:0] railGood;
    logic reloadBtnN;
    logic sourceSwN;
    logic imageSwN;
    logic [2:0] cardSelN;
    logic cardPresent;
    logic cardValid;
    logic cfgDone;
    logic holdJumper;
    logic usbHost;
  } bcs_pins_t;

  typedef struct packed {
    logic [`BCS_ADDR_W-1:0] addr;
    logic [`BCS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bcs_bus_t;
endpackage

/* design/bcs_config_select.sv */
/*
  Configuration source selector: picks flash or boundary-scan chain load,
  times the reload button, drives status indicators and a register port.
  Assumes ref_clk is the 100 MHz system oscillator; all pins are asynchronous.
*/
`timescale 1ns/1ns
`include "bcs_params.svh"
module bcs_config_select #(
  parameter int unsigned HOLD_CYC = `BCS_HOLD_MS * 1000 * `BCS_SYS_CLK_MHZ,
  parameter int unsigned BLINK_CYC = `BCS_BLINK_MS * 1000 * `BCS_SYS_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire bcs_pkg::bcs_pins_t pins,
  input wire bcs_pkg::bcs_bus_t bus,
  output logic [`BCS_DATA_W-1:0] rdata,
  output bcs_pkg::bcs_leds_t leds,
  output logic boardResetN,
  output logic programN,
  output logic flashEnable,
  output logic flashImageSel,
  output logic [2:0] cardImage,
  output bcs_pkg::bcs_port_t chainPort,
  output logic irq
);
  import bcs_pkg::*;

  // ----------------------------------------
  // Timing constants
  // ----------------------------------------
  localparam int unsigned PROG_CYC =
    (`BCS_PROG_NS * `BCS_SYS_CLK_MHZ + 999) / 1000;
  localparam logic [`BCS_HOLD_W-1:0] HOLD_LIM = `BCS_HOLD_W'(HOLD_CYC);
  localparam logic [`BCS_BLINK_W-1:0] BLINK_LAST = `BCS_BLINK_W'(BLINK_CYC - 1);
  localparam logic [`BCS_PROG_W-1:0] PROG_LAST = `BCS_PROG_W'(PROG_CYC - 1);
  localparam int PIN_W = $bits(bcs_pins_t);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] sync_q;
  bcs_pins_t pinS;

  // Not reset: keeps sampling so no false press or rail fault follows reset
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        meta_q[gi] <= pins[gi];
        sync_q[gi] <= meta_q[gi];
      end
    end
  endgenerate

  assign pinS = bcs_pins_t'(sync_q);

  logic railOk;
  logic btnPressed;
  logic cardOk;

  assign railOk = &pinS.railGood;
  assign btnPressed = !pinS.reloadBtnN;
  assign cardOk = pinS.cardPresent && pinS.cardValid;

  // ----------------------------------------
  // State helpers
  // ----------------------------------------
  function automatic logic isLoading(input bcs_state_t s);
    isLoading = (s == ST_START) || (s == ST_FLASH) || (s == ST_CHECK) ||
      (s == ST_CARD) || (s == ST_EXT);
  endfunction

  function automatic logic hit(input logic [`BCS_ADDR_W-1:0] a,
                               input logic [`BCS_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // Reload button hold timer
  // ----------------------------------------
  logic [`BCS_HOLD_W-1:0] holdCnt_q;
  logic btnFire;

  always_ff @(posedge ref_clk) begin
    if (rst || !btnPressed) begin
      holdCnt_q <= '0;
    end else if (holdCnt_q != HOLD_LIM) begin
      holdCnt_q <= holdCnt_q + `BCS_HOLD_W'(1);
    end
  end

  // One shot per press, only after the full hold
  assign btnFire = btnPressed && (holdCnt_q == HOLD_LIM - `BCS_HOLD_W'(1));

  logic ctrlReload;
  logic reloadReq;

  assign ctrlReload = bus.wr && hit(bus.addr, `BCS_REG_CTRL) &&
    bus.wdata[`BCS_CTRL_RELOAD];
  assign reloadReq = btnFire || ctrlReload;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  bcs_state_t state_q;
  bcs_state_t state_d;
  logic chain_q;
  logic fallback_q;
  logic [2:0] cardIdx_q;
  logic [`BCS_PROG_W-1:0] progCnt_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_FAULT: begin
        if (railOk) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_d = ST_START;
      end
      ST_START: begin
        if (progCnt_q == PROG_LAST) begin
          state_d = chain_q ? ST_CHECK : ST_FLASH;
        end
      end
      ST_CHECK: begin
        state_d = cardOk ? ST_CARD : ST_EXT;
      end
      ST_FLASH, ST_CARD, ST_EXT: begin
        if (pinS.cfgDone) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_DONE;
      end
      default: begin
        state_d = ST_FAULT;
      end
    endcase
    if (!railOk) begin
      state_d = ST_FAULT;
    end else if (reloadReq && state_q != ST_FAULT) begin
      state_d = ST_SAMPLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_SAMPLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || state_q != ST_START) begin
      progCnt_q <= '0;
    end else begin
      progCnt_q <= progCnt_q + `BCS_PROG_W'(1);
    end
  end

  // Switches caught only when a load is (re)started
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chain_q <= 1'b0;
      fallback_q <= 1'b0;
      cardIdx_q <= 3'h0;
    end else if (state_q == ST_SAMPLE) begin
      chain_q <= pinS.sourceSwN;
      fallback_q <= !pinS.imageSwN;
      cardIdx_q <= ~pinS.cardSelN;
    end
  end

  // ----------------------------------------
  // Chain port and card fault
  // ----------------------------------------
  logic cardFault_q;

  always_ff @(posedge ref_clk) begin
    if (rst || state_q == ST_SAMPLE) begin
      chainPort <= PORT_CARD;
      cardFault_q <= 1'b0;
    end else if (state_q == ST_CHECK && !cardOk) begin
      chainPort <= pinS.usbHost ? PORT_USB : PORT_PAR;
      cardFault_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Blink timer
  // ----------------------------------------
  logic [`BCS_BLINK_W-1:0] blinkCnt_q;
  logic blink_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      blinkCnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blinkCnt_q == BLINK_LAST) begin
      blinkCnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blinkCnt_q <= blinkCnt_q + `BCS_BLINK_W'(1);
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  bcs_leds_t leds_d;
  logic live;

  assign live = (state_q != ST_FAULT);

  always_comb begin
    leds_d.supplyFault = !live;
    leds_d.flashSrc = live && !chain_q;
    leds_d.chainSrc = live && chain_q;
    leds_d.fallback = live && !chain_q && fallback_q;
    leds_d.done = (state_q == ST_DONE);
    leds_d.activity = chain_q && isLoading(state_q) && blink_q;
    leds_d.loaderFault = cardFault_q && blink_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      leds <= '0;
      boardResetN <= 1'b0;
      programN <= 1'b0;
      flashEnable <= 1'b0;
      flashImageSel <= 1'b0;
      cardImage <= 3'h0;
    end else begin
      leds <= leds_d;
      boardResetN <= (state_d != ST_FAULT);
      programN <= (state_d != ST_START) && (state_d != ST_SAMPLE);
      flashEnable <= !chain_q && (isLoading(state_q) ||
        (state_q == ST_DONE && pinS.holdJumper));
      flashImageSel <= fallback_q;
      cardImage <= cardIdx_q;
    end
  end

  // ----------------------------------------
  // Event status and interrupt
  // ----------------------------------------
  logic [`BCS_EV_W-1:0] status_q;
  logic [`BCS_EV_W-1:0] mask_q;
  logic [`BCS_EV_W-1:0] events;
  logic [`BCS_EV_W-1:0] clr;

  always_comb begin
    events = '0;
    events[`BCS_EV_FAULT] = (state_d == ST_FAULT) && (state_q != ST_FAULT);
    events[`BCS_EV_DONE] = (state_d == ST_DONE) && (state_q != ST_DONE);
    events[`BCS_EV_CARD] = (state_q == ST_CHECK) && !cardOk;
    events[`BCS_EV_PRESS] = btnFire;
    clr = '0;
    if (bus.wr && hit(bus.addr, `BCS_REG_STATUS)) begin
      clr = bus.wdata[`BCS_EV_W-1:0];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= `BCS_EV_RST;
    end else begin
      status_q <= (status_q & ~clr) | events;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_q <= `BCS_MASK_RST;
    end else if (bus.wr && hit(bus.addr, `BCS_REG_MASK)) begin
      mask_q <= bus.wdata[`BCS_EV_W-1:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  logic [`BCS_DATA_W-1:0] stateWord;

  always_comb begin
    stateWord = '0;
    stateWord[`BCS_ST_STATE_LO +: 4] = state_q;
    stateWord[`BCS_ST_FALLBACK] = fallback_q;
    stateWord[`BCS_ST_CHAIN] = chain_q;
    stateWord[`BCS_ST_CARD_LO +: 3] = cardIdx_q;
    stateWord[`BCS_ST_PORT_LO +: 2] = chainPort;
    stateWord[`BCS_ST_DONE] = pinS.cfgDone;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        `BCS_REG_STATUS: rdata <= {{(`BCS_DATA_W-`BCS_EV_W){1'b0}}, status_q};
        `BCS_REG_MASK: rdata <= {{(`BCS_DATA_W-`BCS_EV_W){1'b0}}, mask_q};
        `BCS_REG_STATE: rdata <= stateWord;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_supply_reset_hold: assert property (
    !railOk |=> !boardResetN ##1 leds.supplyFault)
    else $error("supply fault did not hold reset");

  a_short_press_ignored: assert property (
    !btnPressed |=> !btnFire [*2])
    else $error("reload fired without a held press");

  a_hold_restart: assert property (
    btnFire && railOk && state_q != ST_FAULT |=> state_q == ST_SAMPLE ##1 !programN)
    else $error("long press did not restart configuration");

  a_flash_source_led: assert property (
    state_q == ST_FLASH |=> leds.flashSrc && !leds.chainSrc)
    else $error("flash load without flash indicator");

  a_fallback_led: assert property (
    leds.fallback |-> leds.flashSrc && flashImageSel)
    else $error("fallback indicator outside fallback flash load");

  a_image_latched: assert property (
    state_q != ST_SAMPLE |=> $stable(fallback_q))
    else $error("image switch taken outside a restart");

  a_flash_released: assert property (
    state_q == ST_DONE && state_d == ST_DONE && !pinS.holdJumper |=> !flashEnable)
    else $error("flash left enabled after done");

  a_chain_source_led: assert property (
    state_q == ST_CHECK |=> leds.chainSrc && !leds.flashSrc)
    else $error("chain load without chain indicator");

  a_card_pick: assert property (
    state_q == ST_CHECK && cardOk && railOk && !reloadReq |=>
      state_q == ST_CARD ##1 cardImage == $past(cardIdx_q, 2))
    else $error("card image not the selected one");

  a_fault_port: assert property (
    state_q == ST_CHECK && !cardOk && railOk |=>
      chainPort == ($past(pinS.usbHost) ? PORT_USB : PORT_PAR))
    else $error("wrong external port after card fault");

  a_done_led: assert property (
    isLoading(state_q) |=> !leds.done)
    else $error("done indicator on while loading");
endmodule

/* verif/bcs_far_model.sv */
/*
  Far-side model: configuration flash, memory card socket and cable ports.
  Assumes the selector's outputs on the 100 MHz clock; the bench sets card contents.
*/
`timescale 1ns/1ns
module bcs_far_model (
  input wire logic ref_clk,
  input wire logic programN,
  input wire logic flashEnable,
  input wire bcs_pkg::bcs_port_t chainPort,
  input wire logic [7:0] loadCyc,
  input wire logic cardIn,
  input wire logic cardOk,
  output logic cardPresent,
  output logic cardValid,
  output logic cfgDone
);
  import bcs_pkg::*;
  // ----------------------------------------
  // Card socket and data sources
  // ----------------------------------------
  logic [7:0] loadCnt = 8'h00;
  logic doneQ = 1'b0;
  logic srcReady;
  assign cardPresent = cardIn;
  assign cardValid = cardIn & cardOk;
  // Data only from an enabled flash, a valid card or a cable
  assign srcReady = flashEnable | ((chainPort == PORT_CARD) ? (cardIn & cardOk) : 1'b1);
  assign cfgDone = doneQ;
  // ----------------------------------------
  // Load timing, prompt or slow
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!programN) begin
      loadCnt <= 8'h00;
      doneQ <= 1'b0;
    end else if (loadCnt < loadCyc) begin
      loadCnt <= loadCnt + 8'h01;
    end else if (srcReady) begin
      doneQ <= 1'b1;
    end
  end
endmodule

/* verif/tb_top.sv */
/*
  Self-checking bench of the configuration source selector.
  Assumes the far-side model and shortened hold and blink counts.
*/
`timescale 1ns/1ns
`include "bcs_params.svh"
module tb_top;
  import bcs_pkg::*;
  typedef struct {
    logic srcN; logic imgN; logic cIn; logic cOk; logic usb; logic [2:0] selN; logic fb; bcs_port_t port;
  } bcs_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] railGood = 3'h7;
  logic reloadBtnN = 1'b1, sourceSwN = 1'b0, imageSwN = 1'b0, holdJumper = 1'b0, usbHost = 1'b1;
  logic [2:0] cardSelN = 3'h0;
  logic cardIn = 1'b0, cardOk = 1'b0;
  logic [7:0] loadCyc = 8'h03;
  logic cardPresent, cardValid, cfgDone;
  bcs_pins_t pins;
  bcs_bus_t bus = '0;
  logic [31:0] rdata, d;
  bcs_leds_t leds;
  logic boardResetN, programN, flashEnable, flashImageSel, irq, actSeen, faultSeen;
  logic [2:0] cardImage;
  bcs_port_t chainPort;
  int badCount = 0;
  int nChecks = 0;
  bcs_row_t rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b1, PORT_CARD},
    '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0, PORT_CARD},
    '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h5, 1'b0, PORT_CARD},
    '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0, PORT_CARD},
    '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h7, 1'b0, PORT_USB},
    '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h7, 1'b0, PORT_PAR}};
  assign pins = {railGood, reloadBtnN, sourceSwN, imageSwN, cardSelN, cardPresent, cardValid, cfgDone,
    holdJumper, usbHost};
  bcs_config_select #(.HOLD_CYC(20), .BLINK_CYC(4)) dut_u (.ref_clk(ref_clk), .rst(rst), .pins(pins),
    .bus(bus), .rdata(rdata), .leds(leds), .boardResetN(boardResetN), .programN(programN),
    .flashEnable(flashEnable), .flashImageSel(flashImageSel), .cardImage(cardImage),
    .chainPort(chainPort), .irq(irq));
  bcs_far_model far_u (.ref_clk(ref_clk), .programN(programN), .flashEnable(flashEnable),
    .chainPort(chainPort), .loadCyc(loadCyc), .cardIn(cardIn), .cardOk(cardOk),
    .cardPresent(cardPresent), .cardValid(cardValid), .cfgDone(cfgDone));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrapUp;
    $display("Checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic press(input int n);
    @(posedge ref_clk);
    reloadBtnN <= 1'b0;
    repeat (n) @(posedge ref_clk);
    reloadBtnN <= 1'b1;
  endtask
  task automatic wait_done;
    int k;
    actSeen = 1'b0;
    faultSeen = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check(leds.done, 1'b0);
    check(programN, 1'b0);
    for (k = 0; k < 400 && leds.done !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1 actSeen |= leds.activity;
      faultSeen |= leds.loaderFault;
    end
    check(leds.done, 1'b1);
    check(programN, 1'b1);
  endtask
  // ----------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #200000;
    badCount++;
    wrapUp;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 check(boardResetN, 1'b0);
    check(leds, 7'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    wait_done;
    check(leds.fallback, 1'b1);
    for (int i = 0; i < 6; i++) begin
      sourceSwN <= rows[i].srcN;
      imageSwN <= rows[i].imgN;
      cardIn <= rows[i].cIn;
      cardOk <= rows[i].cOk;
      usbHost <= rows[i].usb;
      cardSelN <= rows[i].selN;
      loadCyc <= (i % 2) ? 8'h28 : 8'h03;
      wr_reg(`BCS_REG_CTRL, 32'h1);
      wait_done;
      check(leds.flashSrc, !rows[i].srcN);
      check(leds.chainSrc, rows[i].srcN);
      check(leds.fallback, rows[i].fb);
      check(flashEnable, 1'b0);
      if (rows[i].srcN) begin
        check(chainPort, rows[i].port);
        check(cardImage, 3'(~rows[i].selN));
      end else begin
        check(flashImageSel, rows[i].fb);
      end
      if (i == 3) check(actSeen, 1'b1);
      if (i == 5) check(faultSeen, 1'b1);
    end
    sourceSwN <= 1'b0;
    imageSwN <= 1'b1;
    holdJumper <= 1'b1;
    wr_reg(`BCS_REG_CTRL, 32'h1);
    wait_done;
    check(flashImageSel, 1'b0);
    check(flashEnable, 1'b1);
    wr_reg(`BCS_REG_STATUS, 32'hf);
    imageSwN <= 1'b0;
    press(10);
    repeat (6) @(posedge ref_clk);
    #1 check(flashImageSel, 1'b0);
    check(leds.done, 1'b1);
    holdJumper <= 1'b0;
    press(30);
    wait_done;
    check(flashImageSel, 1'b1);
    check(leds.fallback, 1'b1);
    rd_reg(`BCS_REG_STATUS, d);
    check(d[3:0], 4'ha);
    wr_reg(`BCS_REG_STATUS, 32'hf);
    rd_reg(`BCS_REG_STATUS, d);
    check(d, 32'h0);
    wr_reg(`BCS_REG_MASK, 32'h1);
    #1 check(irq, 1'b0);
    railGood <= 3'h3;
    repeat (4) @(posedge ref_clk);
    #1 check(boardResetN, 1'b0);
    check(leds.supplyFault, 1'b1);
    check(irq, 1'b1);
    railGood <= 3'h7;
    wait_done;
    check(boardResetN, 1'b1);
    check(leds.supplyFault, 1'b0);
    wr_reg(`BCS_REG_STATUS, 32'h1);
    #1 check(irq, 1'b0);
    rd_reg(4'h2, d);
    check(d, 32'h0);
    rd_reg(`BCS_REG_CTRL, d);
    check(d, 32'h0);
    rd_reg(`BCS_REG_STATE, d);
    check(d[5:0], 6'h17);
    wrapUp;
  end
endmodule
